//--- hdl/tpg_defines.vh
// constants for the three-phase gate enable logic
`ifndef TPG_DEFINES_VH
`define TPG_DEFINES_VH

// clock period in ns
`define TPG_CLK_NS 40
// longest time from reset falling to logic reset, in ns
`define TPG_RST_MAX_NS 77
// longest time in cycles, rounded down, never below one
`define TPG_RST_MAX_CYC (((`TPG_RST_MAX_NS / `TPG_CLK_NS) < 1) ? 1 : \
    (`TPG_RST_MAX_NS / `TPG_CLK_NS))
// width of the dead-time count
`define TPG_DT_W 8
// number of half-bridge legs
`define TPG_LEGS 3
// number of pin inputs passed through the synchroniser
`define TPG_SYNC_W 12
// bit positions in the synchroniser vector
`define TPG_SB_HI 0
`define TPG_SB_LO 3
`define TPG_SB_MID 6
`define TPG_SB_OC 9
`define TPG_SB_EN 10
// reset value of the gate outputs
`define TPG_GATE_RST 1'b0
// reset value of the synchroniser: high-side commands idle (high)
`define TPG_SYNC_RST 12'h007

`endif

//--- hdl/tpg_leg.v
// one half-bridge leg: interlock, dead-time blanking and gate flops
`timescale 1ns/1ps
`include "tpg_defines.vh"

module tpg_leg (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_en_ok,
    input wire i_hi_req,
    input wire i_lo_req,
    input wire [`TPG_DT_W-1:0] i_dead_cycles,
    input wire i_dt_bypass,
    input wire i_il_bypass,
    output reg o_hi_gate,
    output reg o_lo_gate
);

    reg [`TPG_DT_W-1:0] dt_cnt_r;
    reg [`TPG_DT_W-1:0] dt_cnt_nxt;
    reg hi_nxt;
    reg lo_nxt;
    wire hi_ok;
    wire lo_ok;
    wire dt_clear;

    // ------------------------------------------------------------
    // interlock and blanking
    // ------------------------------------------------------------
    // both sides requested together cancel each other unless i_il_bypass is set
    assign hi_ok = i_hi_req & (~i_lo_req | i_il_bypass);
    assign lo_ok = i_lo_req & (~i_hi_req | i_il_bypass);
    assign dt_clear = i_dt_bypass | (dt_cnt_r == {`TPG_DT_W{1'b0}});

    always @* begin
        hi_nxt = hi_ok & dt_clear & (~o_lo_gate | i_il_bypass);
        lo_nxt = lo_ok & dt_clear & (~o_hi_gate | i_il_bypass);
        // keep a gate that is already on while it is still wanted
        if (o_hi_gate && hi_ok) begin
            hi_nxt = 1'b1;
        end
        if (o_lo_gate && lo_ok) begin
            lo_nxt = 1'b1;
        end
        dt_cnt_nxt = dt_cnt_r;
        if ((o_hi_gate && !hi_nxt) || (o_lo_gate && !lo_nxt)) begin
            dt_cnt_nxt = i_dead_cycles;
        end else if (!dt_clear) begin
            dt_cnt_nxt = dt_cnt_r - {{(`TPG_DT_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // gate flops
    // ------------------------------------------------------------
    // the enable clears these without waiting for a clock edge
    always @(posedge i_clk or negedge i_en_ok) begin
        if (!i_en_ok) begin
            o_hi_gate <= `TPG_GATE_RST;
            o_lo_gate <= `TPG_GATE_RST;
            dt_cnt_r <= {`TPG_DT_W{1'b0}};
        end else if (!i_rst_n) begin
            o_hi_gate <= `TPG_GATE_RST;
            o_lo_gate <= `TPG_GATE_RST;
            dt_cnt_r <= {`TPG_DT_W{1'b0}};
        end else begin
            o_hi_gate <= hi_nxt;
            o_lo_gate <= lo_nxt;
            dt_cnt_r <= dt_cnt_nxt;
        end
    end

endmodule // tpg_leg

//--- hdl/tpg_top.v
// top of the three-phase gate enable logic
`timescale 1ns/1ps
`include "tpg_defines.vh"

module tpg_top (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_enable_in_a,
    input wire i_enable_in_b,
    input wire i_leg_a_high_cmd_n,
    input wire i_leg_a_low_cmd,
    input wire i_leg_b_high_cmd_n,
    input wire i_leg_b_low_cmd,
    input wire i_leg_c_high_cmd_n,
    input wire i_leg_c_low_cmd,
    input wire i_leg_a_above_half,
    input wire i_leg_b_above_half,
    input wire i_leg_c_above_half,
    input wire i_overcurrent_cmp,
    input wire [`TPG_DT_W-1:0] i_cfg_dead_cycles,
    input wire i_cfg_dt_bypass,
    input wire i_cfg_il_bypass,
    output wire o_leg_a_high_gate,
    output wire o_leg_a_low_gate,
    output wire o_leg_b_high_gate,
    output wire o_leg_b_low_gate,
    output wire o_leg_c_high_gate,
    output wire o_leg_c_low_gate,
    output reg o_gate_pulldown,
    output reg o_leg_a_midpoint_flag,
    output reg o_leg_b_midpoint_flag,
    output reg o_leg_c_midpoint_flag,
    output reg o_overcurrent_flag,
    output reg [`TPG_LEGS-1:0] o_boot_ready
);

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    wire [`TPG_SYNC_W-1:0] pin_raw;
    reg [`TPG_SYNC_W-1:0] sync1_r;
    reg [`TPG_SYNC_W-1:0] sync2_r;
    wire en_ok;
    wire en_sync;
    wire [`TPG_LEGS-1:0] hi_req;
    wire [`TPG_LEGS-1:0] lo_req;
    wire [`TPG_LEGS-1:0] hi_gate;
    wire [`TPG_LEGS-1:0] lo_gate;
    reg [`TPG_LEGS-1:0] boot_ready_nxt;
    reg [`TPG_DT_W-1:0] dead_cycles_r;
    reg dt_bypass_r;
    reg il_bypass_r;

    // ------------------------------------------------------------
    // enable gating
    // ------------------------------------------------------------
    // pure combinational and, feeds the gate clears directly
    assign en_ok = i_enable_in_a & i_enable_in_b;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    assign pin_raw = {i_enable_in_b, i_enable_in_a,
        i_overcurrent_cmp,
        i_leg_c_above_half, i_leg_b_above_half, i_leg_a_above_half,
        i_leg_c_low_cmd, i_leg_b_low_cmd, i_leg_a_low_cmd,
        i_leg_c_high_cmd_n, i_leg_b_high_cmd_n, i_leg_a_high_cmd_n};

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            // idle levels, so no high-side request appears after reset
            sync1_r <= `TPG_SYNC_RST;
            sync2_r <= `TPG_SYNC_RST;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // high-side commands are active low, low-side active high
    assign hi_req = ~sync2_r[`TPG_SB_HI +: `TPG_LEGS];
    assign lo_req = sync2_r[`TPG_SB_LO +: `TPG_LEGS];
    assign en_sync = sync2_r[`TPG_SB_EN] & sync2_r[`TPG_SB_EN+1];

    // ------------------------------------------------------------
    // configuration capture
    // ------------------------------------------------------------
    // settings come from the serial configuration logic
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            dead_cycles_r <= {`TPG_DT_W{1'b0}};
            dt_bypass_r <= 1'b0;
            il_bypass_r <= 1'b0;
        end else begin
            dead_cycles_r <= i_cfg_dead_cycles;
            dt_bypass_r <= i_cfg_dt_bypass;
            il_bypass_r <= i_cfg_il_bypass;
        end
    end

    // ------------------------------------------------------------
    // legs
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `TPG_LEGS; g = g + 1) begin : g_leg
            tpg_leg u_leg (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_en_ok(en_ok),
                .i_hi_req(hi_req[g]),
                .i_lo_req(lo_req[g]),
                .i_dead_cycles(dead_cycles_r),
                .i_dt_bypass(dt_bypass_r),
                .i_il_bypass(il_bypass_r),
                .o_hi_gate(hi_gate[g]),
                .o_lo_gate(lo_gate[g])
            );
        end
    endgenerate

    assign o_leg_a_high_gate = hi_gate[0];
    assign o_leg_a_low_gate = lo_gate[0];
    assign o_leg_b_high_gate = hi_gate[1];
    assign o_leg_b_low_gate = lo_gate[1];
    assign o_leg_c_high_gate = hi_gate[2];
    assign o_leg_c_low_gate = lo_gate[2];

    // ------------------------------------------------------------
    // bootstrap precharge tracking
    // ------------------------------------------------------------
    // a leg is ready once its low side has been on since enabling
    always @* begin
        boot_ready_nxt = o_boot_ready | lo_gate;
        if (!en_sync) begin
            boot_ready_nxt = {`TPG_LEGS{1'b0}};
        end
    end

    // ------------------------------------------------------------
    // status outputs and gate pull-down
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_gate_pulldown <= 1'b1;
            o_leg_a_midpoint_flag <= 1'b0;
            o_leg_b_midpoint_flag <= 1'b0;
            o_leg_c_midpoint_flag <= 1'b0;
            o_overcurrent_flag <= 1'b0;
            o_boot_ready <= {`TPG_LEGS{1'b0}};
        end else begin
            o_gate_pulldown <= 1'b0;
            o_leg_a_midpoint_flag <= sync2_r[`TPG_SB_MID];
            o_leg_b_midpoint_flag <= sync2_r[`TPG_SB_MID+1];
            o_leg_c_midpoint_flag <= sync2_r[`TPG_SB_MID+2];
            o_overcurrent_flag <= sync2_r[`TPG_SB_OC];
            o_boot_ready <= boot_ready_nxt;
        end
    end

endmodule // tpg_top

//--- testbench/tpg_host_model.sv
// host model driving the enables and the six leg commands
`timescale 1ns/1ps
module tpg_host_model (
    input wire i_clk,
    output logic o_en_a = 1'b0,
    output logic o_en_b = 1'b0,
    output logic [2:0] o_hi_n = 3'h7,
    output logic [2:0] o_lo = 3'h0
);
    task drive(input logic a, input logic b, input logic [2:0] h,
               input logic [2:0] l);
        @(posedge i_clk);
        #2;
        o_en_a = a;
        o_en_b = b;
        o_hi_n = h;
        o_lo = l;
    endtask
    // enable, then hold every low side on so the bootstraps charge
    task precharge;
        drive(1'b1, 1'b1, 3'h7, 3'h0);
        drive(1'b1, 1'b1, 3'h7, 3'h7);
    endtask
endmodule // tpg_host_model

//--- testbench/tpg_gate_assertions.sv
// port assertions for the gate enable logic
`timescale 1ns/1ps
module tpg_checker (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_enable_in_a,
    input wire i_enable_in_b,
    input wire i_leg_a_high_cmd_n,
    input wire i_leg_a_low_cmd,
    input wire i_leg_a_above_half,
    input wire i_overcurrent_cmp,
    input wire i_cfg_il_bypass,
    input wire o_leg_a_high_gate,
    input wire o_leg_a_low_gate,
    input wire o_leg_b_high_gate,
    input wire o_leg_b_low_gate,
    input wire o_leg_c_high_gate,
    input wire o_leg_c_low_gate,
    input wire o_gate_pulldown,
    input wire o_leg_a_midpoint_flag,
    input wire o_overcurrent_flag
);
    wire [5:0] g = {o_leg_c_high_gate, o_leg_c_low_gate, o_leg_b_high_gate,
        o_leg_b_low_gate, o_leg_a_high_gate, o_leg_a_low_gate};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_EN_OFF: assert property (!(i_enable_in_a && i_enable_in_b)
        |-> g == 6'h00) else $error("gate on while disabled");
    AST_RST_OFF: assert property (disable iff (1'b0) !i_rst_n
        |=> g == 6'h00 && o_gate_pulldown) else $error("reset not applied");
    AST_PD_OFF: assert property (i_rst_n [*2] |-> !o_gate_pulldown)
        else $error("pull-down after reset");
    AST_IL: assert property ((!i_cfg_il_bypass) [*3] |->
        (g & (g >> 1) & 6'h15) == 6'h00) else $error("both sides on");
    AST_HI_POL: assert property (i_leg_a_high_cmd_n [*4]
        |-> !o_leg_a_high_gate) else $error("high gate without command");
    AST_LO_POL: assert property ((!i_leg_a_low_cmd) [*4]
        |-> !o_leg_a_low_gate) else $error("low gate without command");
    AST_MID: assert property ($stable(i_leg_a_above_half) [*4]
        |-> o_leg_a_midpoint_flag == i_leg_a_above_half)
        else $error("midpoint flag wrong");
    AST_OC: assert property ($stable(i_overcurrent_cmp) [*4]
        |-> o_overcurrent_flag == i_overcurrent_cmp)
        else $error("overcurrent flag wrong");
    cover property (o_leg_a_high_gate);
    cover property (o_leg_a_high_gate && o_leg_a_low_gate);
    cover property ($fell(i_enable_in_b));
endmodule // tpg_checker
bind tpg_top tpg_checker chk (.i_clk, .i_rst_n, .i_enable_in_a,
    .i_enable_in_b, .i_leg_a_high_cmd_n, .i_leg_a_low_cmd,
    .i_leg_a_above_half, .i_overcurrent_cmp, .i_cfg_il_bypass,
    .o_leg_a_high_gate, .o_leg_a_low_gate, .o_leg_b_high_gate,
    .o_leg_b_low_gate, .o_leg_c_high_gate, .o_leg_c_low_gate,
    .o_gate_pulldown, .o_leg_a_midpoint_flag, .o_overcurrent_flag);

//--- testbench/tb_top.sv
// bench for the three-phase gate enable logic
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst_n = 0, oc = 0, dtb = 0, ilb = 0, ea, eb, pd, ocf;
    logic [2:0] abv = 0, hn, lo, rdy, mf;
    logic [5:0] g;
    int failures = 0, cmp_count = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    tpg_host_model host (.i_clk(clk), .o_en_a(ea), .o_en_b(eb),
        .o_hi_n(hn), .o_lo(lo));
    tpg_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_enable_in_a(ea),
        .i_enable_in_b(eb), .i_leg_a_high_cmd_n(hn[0]),
        .i_leg_a_low_cmd(lo[0]), .i_leg_b_high_cmd_n(hn[1]),
        .i_leg_b_low_cmd(lo[1]), .i_leg_c_high_cmd_n(hn[2]),
        .i_leg_c_low_cmd(lo[2]), .i_leg_a_above_half(abv[0]),
        .i_leg_b_above_half(abv[1]), .i_leg_c_above_half(abv[2]),
        .i_overcurrent_cmp(oc), .i_cfg_dead_cycles(8'h04),
        .i_cfg_dt_bypass(dtb), .i_cfg_il_bypass(ilb),
        .o_leg_a_high_gate(g[1]), .o_leg_a_low_gate(g[0]),
        .o_leg_b_high_gate(g[3]), .o_leg_b_low_gate(g[2]),
        .o_leg_c_high_gate(g[5]), .o_leg_c_low_gate(g[4]),
        .o_gate_pulldown(pd), .o_leg_a_midpoint_flag(mf[0]),
        .o_leg_b_midpoint_flag(mf[1]), .o_leg_c_midpoint_flag(mf[2]),
        .o_overcurrent_flag(ocf), .o_boot_ready(rdy));
    task chk(input string n, input logic [5:0] e, input logic [5:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            give_verdict();
        end
    end
    task t_boot;
        host.precharge();
        ticks(2);
        chk("low early", 0, g);
        ticks(1);
        chk("low on", 6'h15, g);
        host.drive(1, 1, 3'h6, 3'h0);
        ticks(4);
        chk("low off", 0, g);
        chk("boot ready", 7, rdy);
    endtask
    task t_high;
        host.drive(1, 1, 3'h6, 3'h0);
        ticks(2);
        chk("dead time", 0, g);
        for (int n = 0; n < 20 && g[1] !== 1'b1; n++) ticks(1);
        chk("high on", 6'h02, g);
    endtask
    task t_enable;
        host.drive(1, 0, 3'h6, 3'h0);
        #1 chk("async off", 0, g);
        ticks(5);
        chk("b low", 0, g);
        chk("boot clear", 0, rdy);
        host.drive(0, 1, 3'h6, 3'h0);
        ticks(5);
        chk("a low", 0, g);
    endtask
    task t_lock;
        host.precharge();
        host.drive(1, 1, 3'h6, 3'h1);
        ticks(8);
        chk("interlock", 0, g);
        @(posedge clk) #2 {ilb, dtb} = 2'b11;
        ticks(8);
        chk("override", 6'h03, g);
        host.drive(1, 1, 3'h7, 3'h0);
        ticks(5);
        @(posedge clk) #2 {ilb, dtb} = 2'b00;
    endtask
    task t_flags;
        @(posedge clk) #2 {abv, oc} = 4'hb;
        ticks(4);
        chk("flags", 6'h0b, {2'h0, mf, ocf});
        @(posedge clk) #2 {abv, oc} = 4'h4;
        ticks(4);
        chk("flags", 6'h04, {2'h0, mf, ocf});
    endtask
    initial begin
        ticks(6);
        chk("pulldown", 1, pd);
        chk("reset gates", 0, g);
        @(posedge clk) #2 rst_n = 1;
        ticks(2);
        chk("pulldown", 0, pd);
        t_boot();
        t_high();
        t_enable();
        t_lock();
        t_flags();
        host.precharge();
        ticks(4);
        @(posedge clk) #2 rst_n = 0;
        #75 chk("reset gates", 0, g);
        chk("pulldown", 1, pd);
        @(posedge clk) #2 rst_n = 1;
        ticks(1);
        chk("release gates", 0, g);
        ticks(1);
        chk("release gates", 0, g);
        give_verdict();
    end
endmodule // tb_top
